/* hw/fault_delay_filter.sv */
// persistence filter: output follows input once it has held for a fixed count
`timescale 1ns/10ps
`include "pol_fault_params.svh"
module fault_delay_filter #(
    parameter int DELAY = `PFS_FILTER_CYCLES,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw,
    output logic filtered
);
    localparam int CW = $clog2(DELAY + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY - 1);
    logic [CW-1:0] cnt;

    // ==========================================================
    // filter
    // a glitch shorter than the delay restarts the count, so it never leaks out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            filtered <= RESET_VAL;
        end else if (raw == filtered) begin
            cnt <= '0;
        end else if (cnt == LAST) begin
            cnt <= '0;
            filtered <= raw;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // ==========================================================
    // checks
    chk_hold_before_change: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(filtered) |-> $past(cnt) == LAST && $past(raw) == filtered)
        else $error("filter output changed before the input held long enough");
endmodule

/* hw/pol_fault_params.svh */
// offsets, field positions, reset values and timing counts of the fault supervisor
`ifndef POL_FAULT_PARAMS_SVH
`define POL_FAULT_PARAMS_SVH

// ==========================================================
// timing
`define PFS_CLK_MHZ 100
`define PFS_FILTER_DELAY_NS 6000
`define PFS_FILTER_CYCLES ((`PFS_FILTER_DELAY_NS * `PFS_CLK_MHZ) / 1000)
`define PFS_RETRY_MS 130
`define PFS_RETRY_CYCLES (`PFS_RETRY_MS * `PFS_CLK_MHZ * 1000)

// ==========================================================
// register offsets
`define PFS_CTRL_OFS 8'h00
`define PFS_THRESH_OFS 8'h04
`define PFS_SETPOINT_OFS 8'h08
`define PFS_RATED_OFS 8'h0C
`define PFS_STATUS_OFS 8'h10
`define PFS_INT_STATUS_OFS 8'h14
`define PFS_INT_CLEAR_OFS 8'h18
`define PFS_INT_ENABLE_OFS 8'h1C

// ==========================================================
// field positions
`define PFS_CTRL_ENABLE_BIT 0
`define PFS_CTRL_TRACK_BIT 1
`define PFS_CTRL_LATCH_LSB 2
`define PFS_THR_OC_LSB 0
`define PFS_THR_OV_LSB 4
`define PFS_THR_UV_LSB 6
`define PFS_THR_PG_BIT 8

// ==========================================================
// reset values
`define PFS_CTRL_RESET 7'h00
`define PFS_OC_STEP_RESET 4'hA
`define PFS_OV_STEP_RESET 2'h2
`define PFS_UV_STEP_RESET 2'h0
`define PFS_PG_STEP_RESET 1'h0
`define PFS_SETPOINT_RESET 16'h01F4
`define PFS_RATED_RESET 16'h4E20

// ==========================================================
// thresholds, percent and mV and degrees C
`define PFS_OC_PCT_BASE 8'h28
`define PFS_OC_PCT_STEP 8'h0A
`define PFS_OC_STEP_MAX 4'hA
`define PFS_OV_PCT_BASE 8'h6E
`define PFS_OV_PCT_STEP 8'h0A
`define PFS_UV_PCT_BASE 8'h4B
`define PFS_UV_PCT_STEP 8'h05
`define PFS_VSTEP_MAX 2'h2
`define PFS_PG_LOW_BASE 8'h5A
`define PFS_PG_LOW_STEP 8'h05
`define PFS_PG_HIGH_PCT 8'h6E
`define PFS_OV_FLOOR_MV 24'h00_03E8
`define PFS_TRACK_BAND_MV 16'h00FA
`define PFS_OT_OFF_C 10'h082
`define PFS_OT_ON_C 10'h078
`define PFS_WARN_SET_C 10'h078
`define PFS_WARN_CLR_C 10'h075

`endif

/* hw/pol_fault_pkg.sv */
// types of the fault supervisor
package pol_fault_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RUN = 2'b01,
        ST_RETRY = 2'b10,
        ST_LATCHED = 2'b11
    } supervisor_state_t;
endpackage

/* hw/pol_fault_protection_supervisor.sv */
// fault-protection and power-good supervisor for a step-down converter, apb registers
//
// Summary of operation
// - overcurrent trips retry restart every 130 ms by default, or latch when so configured.
// - the overcurrent threshold is one of 11 percent-of-rated steps topping out at 140 percent.
// - the overvoltage threshold is 110, 120 or 130 percent of setpoint, 130 after reset.
// - the effective overvoltage level never falls below 1.0 V.
// - voltage, temperature and tracking faults turn the converter off 6 us after crossing.
// - the undervoltage threshold is 75, 80 or 85 percent of setpoint, 75 after reset.
// - overtemperature shuts down at 130 C and allows restart only once cooled to 120 C.
// - tracking protection, off by default, trips beyond 250 mV deviation during ramp-up only.
// - an always-on temperature warning sets at 120 C with 3 C hysteresis, shown in status.
// - the temperature warning asserts 6 us after crossing its threshold.
// - power good is high inside a 90 or 95 to 110 percent window and low outside it.
// - power good changes state 6 us after the voltage crosses a window bound.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "pol_fault_params.svh"
module pol_fault_protection_supervisor
    import pol_fault_pkg::*;
#(
    parameter int RETRY_CYCLES = `PFS_RETRY_CYCLES,
    parameter int FILTER_CYCLES = `PFS_FILTER_CYCLES,
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] vout_mv,
    input wire logic [15:0] iout_ma,
    input wire logic signed [9:0] temp_c,
    input wire logic [15:0] track_ref_mv,
    input wire logic ramp_up,
    output logic shutdown_req,
    output logic power_good_output,
    output logic ot_warning,
    output logic irq
);
    localparam int RW = $clog2(RETRY_CYCLES + 1);
    localparam logic [RW-1:0] RETRY_LAST = RW'(RETRY_CYCLES - 1);
    localparam logic signed [9:0] OT_OFF = `PFS_OT_OFF_C;
    localparam logic signed [9:0] OT_ON = `PFS_OT_ON_C;
    localparam logic signed [9:0] WARN_SET = `PFS_WARN_SET_C;
    localparam logic signed [9:0] WARN_CLR = `PFS_WARN_CLR_C;
    localparam logic [7:0] HUNDRED = 8'h64;

    // ==========================================================
    // registers
    logic out_enable;
    logic track_en;
    logic [4:0] latch_mode;
    logic [3:0] oc_step;
    logic [1:0] ov_step;
    logic [1:0] uv_step;
    logic pg_step;
    logic [15:0] setpoint_mv;
    logic [15:0] rated_ma;
    logic [6:0] int_status;
    logic [6:0] int_enable;
    supervisor_state_t state;
    logic [RW-1:0] retry_cnt;

    logic wr_en;
    logic rd_setup;
    logic unmapped;
    logic [31:0] next_rdata;
    logic [6:0] clr_mask;
    logic [4:0] fault_flags;

    function automatic logic [23:0] pct_of(input logic [15:0] base, input logic [7:0] pct);
        pct_of = {8'h00, base} * {16'h0000, pct};
    endfunction

    // ==========================================================
    // apb slave
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pslverr = psel && penable && unmapped;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unmapped = 1'b0;
        if (paddr == `PFS_CTRL_OFS) begin
            next_rdata[6:0] = {latch_mode, track_en, out_enable};
        end else if (paddr == `PFS_THRESH_OFS) begin
            next_rdata[8:0] = {pg_step, uv_step, ov_step, oc_step};
        end else if (paddr == `PFS_SETPOINT_OFS) begin
            next_rdata[15:0] = setpoint_mv;
        end else if (paddr == `PFS_RATED_OFS) begin
            next_rdata[15:0] = rated_ma;
        end else if (paddr == `PFS_STATUS_OFS) begin
            next_rdata[8:0] = {state, power_good_output, ot_warning, fault_flags};
        end else if (paddr == `PFS_INT_STATUS_OFS) begin
            next_rdata[6:0] = int_status;
        end else if (paddr == `PFS_INT_CLEAR_OFS) begin
            next_rdata = 32'h0000_0000;
        end else if (paddr == `PFS_INT_ENABLE_OFS) begin
            next_rdata[6:0] = int_enable;
        end else begin
            unmapped = 1'b1;
        end
    end

    // read data is captured in the setup cycle so the access cycle sees a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {latch_mode, track_en, out_enable} <= `PFS_CTRL_RESET;
            oc_step <= `PFS_OC_STEP_RESET;
            ov_step <= `PFS_OV_STEP_RESET;
            uv_step <= `PFS_UV_STEP_RESET;
            pg_step <= `PFS_PG_STEP_RESET;
            setpoint_mv <= `PFS_SETPOINT_RESET;
            rated_ma <= `PFS_RATED_RESET;
            int_enable <= 7'h00;
        end else if (wr_en) begin
            if (paddr == `PFS_CTRL_OFS) begin
                out_enable <= pwdata[`PFS_CTRL_ENABLE_BIT];
                track_en <= pwdata[`PFS_CTRL_TRACK_BIT];
                latch_mode <= pwdata[`PFS_CTRL_LATCH_LSB +: 5];
            end else if (paddr == `PFS_THRESH_OFS) begin
                oc_step <= pwdata[`PFS_THR_OC_LSB +: 4];
                ov_step <= pwdata[`PFS_THR_OV_LSB +: 2];
                uv_step <= pwdata[`PFS_THR_UV_LSB +: 2];
                pg_step <= pwdata[`PFS_THR_PG_BIT];
            end else if (paddr == `PFS_SETPOINT_OFS) begin
                setpoint_mv <= pwdata[15:0];
            end else if (paddr == `PFS_RATED_OFS) begin
                rated_ma <= pwdata[15:0];
            end else if (paddr == `PFS_INT_ENABLE_OFS) begin
                int_enable <= pwdata[6:0];
            end
        end
    end

    // ==========================================================
    // thresholds
    logic [3:0] oc_eff;
    logic [1:0] ov_eff;
    logic [1:0] uv_eff;
    logic [7:0] oc_pct;
    logic [7:0] ov_pct;
    logic [7:0] uv_pct;
    logic [7:0] pg_low_pct;
    logic [23:0] vout_x100;
    logic [23:0] ov_level;
    logic [23:0] ov_floor_x100;
    logic [23:0] ov_eff_level;
    logic [16:0] track_diff;

    // out-of-range codes clamp to the top step instead of wrapping
    assign oc_eff = (oc_step > `PFS_OC_STEP_MAX) ? `PFS_OC_STEP_MAX : oc_step;
    assign ov_eff = (ov_step > `PFS_VSTEP_MAX) ? `PFS_VSTEP_MAX : ov_step;
    assign uv_eff = (uv_step > `PFS_VSTEP_MAX) ? `PFS_VSTEP_MAX : uv_step;
    assign oc_pct = `PFS_OC_PCT_BASE + `PFS_OC_PCT_STEP * {4'h0, oc_eff};
    assign ov_pct = `PFS_OV_PCT_BASE + `PFS_OV_PCT_STEP * {6'h00, ov_eff};
    assign uv_pct = `PFS_UV_PCT_BASE + `PFS_UV_PCT_STEP * {6'h00, uv_eff};
    assign pg_low_pct = `PFS_PG_LOW_BASE + (pg_step ? `PFS_PG_LOW_STEP : 8'h00);

    assign vout_x100 = pct_of(vout_mv, HUNDRED);
    assign ov_level = pct_of(setpoint_mv, ov_pct);
    assign ov_floor_x100 = 24'(`PFS_OV_FLOOR_MV * HUNDRED);
    assign ov_eff_level = (ov_level < ov_floor_x100) ? ov_floor_x100 : ov_level;
    assign track_diff = (vout_mv > track_ref_mv) ? {1'b0, vout_mv} - {1'b0, track_ref_mv}
                                                 : {1'b0, track_ref_mv} - {1'b0, vout_mv};

    // ==========================================================
    // raw comparisons
    logic oc_raw;
    logic ov_raw;
    logic uv_raw;
    logic trk_raw;
    logic pg_raw;
    logic ot_hyst;
    logic warn_raw;

    assign oc_raw = pct_of(iout_ma, HUNDRED) > pct_of(rated_ma, oc_pct);
    assign ov_raw = vout_x100 > ov_eff_level;
    // undervoltage is blanked while the output ramps, else every soft start would trip it
    assign uv_raw = (state == ST_RUN) && !ramp_up
                    && (vout_x100 < pct_of(setpoint_mv, uv_pct));
    assign trk_raw = track_en && ramp_up && (track_diff > {1'b0, `PFS_TRACK_BAND_MV});
    assign pg_raw = (vout_x100 >= pct_of(setpoint_mv, pg_low_pct))
                    && (vout_x100 <= pct_of(setpoint_mv, `PFS_PG_HIGH_PCT));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_hyst <= 1'b0;
        end else if (temp_c >= OT_OFF) begin
            ot_hyst <= 1'b1;
        end else if (temp_c <= OT_ON) begin
            ot_hyst <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_raw <= 1'b0;
        end else if (temp_c >= WARN_SET) begin
            warn_raw <= 1'b1;
        end else if (temp_c <= WARN_CLR) begin
            warn_raw <= 1'b0;
        end
    end

    // ==========================================================
    // delay filters
    logic [5:0] filt_in;
    logic [5:0] filt_out;
    assign filt_in = {pg_raw, warn_raw, trk_raw, ot_hyst, uv_raw, ov_raw};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_filt
            fault_delay_filter #(
                .DELAY(FILTER_CYCLES),
                .RESET_VAL(1'b0)
            ) u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .raw(filt_in[gi]),
                .filtered(filt_out[gi])
            );
        end
    endgenerate

    // overcurrent acts at once, no persistence
    assign fault_flags = {filt_out[3:0], oc_raw};
    assign ot_warning = filt_out[4];
    assign power_good_output = filt_out[5];

    // ==========================================================
    // shutdown and recovery
    logic any_trip;
    logic latch_trip;
    assign any_trip = |fault_flags;
    assign latch_trip = |(fault_flags & latch_mode);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
        end else if (!out_enable) begin
            state <= ST_OFF;
        end else begin
            case (state)
                ST_OFF: begin
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    if (latch_trip) begin
                        state <= ST_LATCHED;
                    end else if (any_trip) begin
                        state <= ST_RETRY;
                    end
                end
                ST_RETRY: begin
                    if (retry_cnt == RETRY_LAST && !ot_hyst && !fault_flags[3]) begin
                        state <= ST_RUN;
                    end
                end
                ST_LATCHED: begin
                    state <= ST_LATCHED;
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // the count saturates, so a hot part restarts as soon as its filtered overtemperature flag clears after cooling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry_cnt <= '0;
        end else if (state != ST_RETRY) begin
            retry_cnt <= '0;
        end else if (retry_cnt != RETRY_LAST) begin
            retry_cnt <= retry_cnt + 1'b1;
        end
    end

    assign shutdown_req = (state != ST_RUN);

    // ==========================================================
    // interrupts
    logic [6:0] events;
    logic [4:0] flags_q;
    logic warn_q;
    logic pg_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 5'h00;
            warn_q <= 1'b0;
            pg_q <= 1'b0;
        end else begin
            flags_q <= fault_flags;
            warn_q <= ot_warning;
            pg_q <= power_good_output;
        end
    end

    assign events = {pg_q & ~power_good_output, ot_warning & ~warn_q, fault_flags & ~flags_q};
    assign clr_mask = (wr_en && paddr == `PFS_INT_CLEAR_OFS) ? pwdata[6:0] : 7'h00;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= 7'h00;
        end else begin
            int_status <= (int_status & ~clr_mask) | events;
        end
    end

    assign irq = |(int_status & int_enable);

    // ==========================================================
    // checks
    chk_oc_immediate: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_RUN && out_enable && oc_raw |=> shutdown_req)
        else $error("overcurrent did not shut down on the next edge");
    chk_ov_floor: assert property (@(posedge pclk) disable iff (!presetn)
        ov_raw |-> vout_mv > 16'h03E8)
        else $error("overvoltage seen below the 1.0 V floor");
    chk_retry_period: assert property (@(posedge pclk) disable iff (!presetn)
        $past(state) == ST_RETRY && state == ST_RUN |-> $past(retry_cnt) == RETRY_LAST)
        else $error("restart before the retry period ran out");
    chk_latched_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_LATCHED && out_enable |=> state == ST_LATCHED && shutdown_req)
        else $error("latched trip left without an enable cycle");
    chk_latch_select: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_RUN && out_enable && any_trip && !latch_trip |=> state == ST_RETRY)
        else $error("non-latching trip did not enter retry");
    chk_ot_restart: assert property (@(posedge pclk) disable iff (!presetn)
        $past(state) == ST_RETRY && state == ST_RUN |-> !$past(ot_hyst))
        else $error("restart while still over temperature");
    chk_track_gate: assert property (@(posedge pclk) disable iff (!presetn)
        trk_raw |-> track_en && ramp_up)
        else $error("tracking fault outside an enabled ramp-up");
    chk_warn_set: assert property (@(posedge pclk) disable iff (!presetn)
        temp_c >= WARN_SET |=> warn_raw)
        else $error("warning not armed at its threshold");
    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        events[0] |=> int_status[0])
        else $error("event lost against a clear");

    cov_retry_restart: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_RETRY ##1 state == ST_RUN);
    cov_latched: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_RUN ##1 state == ST_LATCHED);
    cov_pg_rise: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(power_good_output));
    cov_warn_rise: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(ot_warning));
endmodule

/* verification/pol_fault_protection_supervisor_tb.sv */
// self-checking testbench of the fault-protection supervisor
`timescale 1ns/10ps
`include "pol_fault_params.svh"
module pol_fault_protection_supervisor_tb;
    import pol_fault_pkg::*;
    // ==========================================================
    // short counts keep the run brief; expectations scale with them
    localparam int RETRY = 50;
    localparam int FILT = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic ramp_up, shutdown_req, power_good_output, ot_warning, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, ctrl_run;
    logic [15:0] vout_mv, iout_ma, track_ref_mv, vnom;
    logic signed [9:0] temp_c;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    pol_fault_protection_supervisor #(.RETRY_CYCLES(RETRY), .FILTER_CYCLES(FILT)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vout_mv(vout_mv), .iout_ma(iout_ma), .temp_c(temp_c),
        .track_ref_mv(track_ref_mv), .ramp_up(ramp_up), .shutdown_req(shutdown_req),
        .power_good_output(power_good_output), .ot_warning(ot_warning), .irq(irq));
    // ==========================================================
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    // ==========================================================
    // tasks
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // pready is awaited, never assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        chk("pslverr", {31'd0, (a > 8'h1C)}, {31'd0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic st(input logic [1:0] exp);
        apb(1'b0, `PFS_STATUS_OFS, 32'h0000_0000);
        chk("state", {30'd0, exp}, {30'd0, rd[8:7]});
    endtask
    // quiet inputs, restart, then one disturbed input
    task automatic probe(input int kind, input logic [15:0] v, input logic exp, input int w);
        @(posedge pclk);
        vout_mv <= vnom;
        iout_ma <= 16'h03E8;
        temp_c <= 10'sd25;
        tick(FILT + 4);
        apb(1'b1, `PFS_CTRL_OFS, 32'h0000_0000);
        apb(1'b1, `PFS_CTRL_OFS, ctrl_run);
        @(posedge pclk);
        if (kind == 0) vout_mv <= v;
        else if (kind == 1) iout_ma <= v;
        else temp_c <= signed'(v[9:0]);
        tick(w);
        chk("shutdown_req", {31'd0, exp}, {31'd0, shutdown_req});
    endtask
    task automatic pg_at(input logic [15:0] v, input logic exp);
        @(posedge pclk);
        vout_mv <= v;
        tick(FILT + 4);
        chk("power_good", {31'd0, exp}, {31'd0, power_good_output});
    endtask
    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, ramp_up} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        vnom = 16'd500;
        vout_mv = 16'd500;
        iout_ma = 16'h03E8;
        temp_c = 10'sd25;
        track_ref_mv = 16'd2000;
        ctrl_run = 32'h0000_0001;
        tick(5);
        presetn <= 1'b1;
        chk("off_in_reset", 32'h1, {31'd0, shutdown_req});
        apb(1'b0, `PFS_CTRL_OFS, 32'h0000_0000);
        chk("ctrl", 32'h0000_0000, rd);
        apb(1'b0, `PFS_THRESH_OFS, 32'h0000_0000);
        chk("thresh", 32'h0000_002A, rd);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        $display("test reset done");
        // floor wins over 130 percent of a 500 mV setpoint
        probe(0, 16'd900, 1'b0, FILT + 4);
        probe(0, 16'd1000, 1'b0, FILT + 4);
        probe(0, 16'd1001, 1'b1, FILT + 4);
        st(2'd2);
        vout_mv <= vnom;
        tick(RETRY - 15);
        st(2'd2);
        tick(20);
        st(2'd1);
        apb(1'b1, `PFS_INT_ENABLE_OFS, 32'h0000_0002);
        tick(1);
        chk("irq_on", 32'h1, {31'd0, irq});
        apb(1'b1, `PFS_INT_ENABLE_OFS, 32'h0000_0000);
        tick(1);
        chk("irq_masked", 32'h0, {31'd0, irq});
        apb(1'b0, `PFS_INT_STATUS_OFS, 32'h0000_0000);
        chk("int_ov", 32'h1, {31'd0, rd[1]});
        apb(1'b1, `PFS_INT_CLEAR_OFS, 32'h0000_007F);
        apb(1'b1, `PFS_INT_ENABLE_OFS, 32'h0000_0002);
        tick(1);
        chk("irq_cleared", 32'h0, {31'd0, irq});
        $display("test floor done");
        apb(1'b1, `PFS_SETPOINT_OFS, 32'h0000_07D0);
        vnom = 16'd2000;
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, `PFS_THRESH_OFS, 32'(s * 16 + s * 64 + 10));
            probe(0, 16'(2200 + 200 * s), 1'b0, FILT + 4);
            probe(0, 16'(2201 + 200 * s), 1'b1, FILT + 4);
            probe(0, 16'(1501 + 100 * s), 1'b0, FILT + 4);
            probe(0, 16'(1499 + 100 * s), 1'b1, FILT + 4);
        end
        probe(0, 16'd2601, 1'b0, FILT - 1);
        tick(4);
        chk("ov_delay", 32'h1, {31'd0, shutdown_req});
        apb(1'b1, `PFS_THRESH_OFS, 32'h0000_002A);
        ctrl_run = 32'h0000_0009;
        probe(0, 16'd2601, 1'b1, FILT + 4);
        tick(RETRY + 10);
        st(2'd3);
        $display("test voltage done");
        ctrl_run = 32'h0000_0001;
        for (int s = 0; s < 11; s++) begin
            apb(1'b1, `PFS_THRESH_OFS, 32'(32 + s));
            probe(1, 16'(8000 + 2000 * s), 1'b0, 3);
            probe(1, 16'(8001 + 2000 * s), 1'b1, 3);
        end
        st(2'd2);
        iout_ma <= 16'h03E8;
        tick(RETRY - 15);
        st(2'd2);
        tick(20);
        st(2'd1);
        ctrl_run = 32'h0000_0005;
        probe(1, 16'd28001, 1'b1, 3);
        iout_ma <= 16'h03E8;
        tick(RETRY + 10);
        st(2'd3);
        apb(1'b1, `PFS_CTRL_OFS, 32'h0000_0000);
        st(2'd0);
        apb(1'b1, `PFS_CTRL_OFS, ctrl_run);
        st(2'd1);
        $display("test current done");
        ctrl_run = 32'h0000_0001;
        probe(2, 16'd119, 1'b0, FILT + 4);
        chk("warn_119", 32'h0, {31'd0, ot_warning});
        temp_c <= 10'sd120;
        tick(FILT - 1);
        chk("warn_early", 32'h0, {31'd0, ot_warning});
        tick(4);
        chk("warn_set", 32'h1, {31'd0, ot_warning});
        apb(1'b0, `PFS_STATUS_OFS, 32'h0000_0000);
        chk("warn_status", 32'h1, {31'd0, rd[5]});
        temp_c <= 10'sd129;
        tick(FILT + 4);
        chk("ot_129", 32'h0, {31'd0, shutdown_req});
        temp_c <= 10'sd130;
        tick(FILT + 4);
        chk("ot_130", 32'h1, {31'd0, shutdown_req});
        temp_c <= 10'sd121;
        tick(RETRY + FILT + 10);
        st(2'd2);
        temp_c <= 10'sd120;
        tick(FILT + 4);
        st(2'd1);
        temp_c <= 10'sd118;
        tick(FILT + 4);
        chk("warn_118", 32'h1, {31'd0, ot_warning});
        temp_c <= 10'sd117;
        tick(FILT + 4);
        chk("warn_117", 32'h0, {31'd0, ot_warning});
        $display("test temperature done");
        pg_at(16'd1800, 1'b1);
        pg_at(16'd2200, 1'b1);
        pg_at(16'd2201, 1'b0);
        pg_at(16'd1800, 1'b1);
        vout_mv <= 16'd1799;
        tick(FILT - 1);
        chk("pg_early", 32'h1, {31'd0, power_good_output});
        tick(4);
        chk("pg_low", 32'h0, {31'd0, power_good_output});
        apb(1'b1, `PFS_THRESH_OFS, 32'h0000_012A);
        pg_at(16'd1899, 1'b0);
        pg_at(16'd1900, 1'b1);
        $display("test power good done");
        // reference is held at the 2000 mV nominal so only the probe deviates
        ramp_up <= 1'b1;
        probe(0, 16'd2400, 1'b0, FILT + 4);
        ctrl_run = 32'h0000_0003;
        probe(0, 16'd2250, 1'b0, FILT + 4);
        probe(0, 16'd2251, 1'b1, FILT + 4);
        probe(0, 16'd1749, 1'b1, FILT + 4);
        ramp_up <= 1'b0;
        probe(0, 16'd2400, 1'b0, FILT + 4);
        $display("test tracking done");
        wrap_up();
    end
endmodule
